// file: common/etm_pkg.sv
// Purpose: Shared constants and types for the emulator trace and memory map block
// Assumes: One 100 MHz clock; register port with one-cycle read latency
// Notes: All offsets are word indices on the register port
package etm_pkg;
    // Memory map
    localparam int BLOCK_COUNT = 32;
    localparam int BLOCK_BYTES = 2048;
    localparam int ADDR_W = 16;
    localparam int BLOCK_IDX_W = 5;
    // Trace
    localparam int CHAN_W = 42;
    localparam int EXT_W = 18;
    localparam int TRACE_DEPTH = 1023;
    localparam int TRACE_PTR_W = 10;
    localparam int TRACE_MAX_COUNT = 1022;
    localparam logic [TRACE_PTR_W-1:0] TRACE_LAST_IDX = 10'h3FE;
    localparam logic [TRACE_PTR_W-1:0] TRACE_COUNT_MAX = 10'h3FE;
    // Register port
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h01;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h02;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
    localparam logic [7:0] OFF_CYCLE_LOW = 8'h04;
    localparam logic [7:0] OFF_CYCLE_HIGH = 8'h05;
    localparam logic [7:0] OFF_LAST_INSTR = 8'h06;
    localparam logic [7:0] OFF_FRAME_COUNT = 8'h07;
    localparam logic [7:0] OFF_TRACE_INDEX = 8'h08;
    localparam logic [7:0] OFF_TRACE_LOW = 8'h09;
    localparam logic [7:0] OFF_TRACE_HIGH = 8'h0A;
    localparam logic [7:0] OFF_MATCH_BASE = 8'h10; // 4 matchers x 4 words
    localparam logic [7:0] OFF_MAP_BASE = 8'h20;   // 32 map entries
    localparam logic [7:0] OFF_MAP_END = 8'h3F;
    // Control bits
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_CLEAR_BIT = 1;
    // Interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_NONEXIST_BIT = 0;
    localparam int IRQ_BREAK_BIT = 1;
    localparam int IRQ_WRAP_BIT = 2;
    // Reset values
    localparam logic [REG_DATA_W-1:0] RESET_WORD = 32'h00000000;

    // Per-block destination
    typedef enum logic [1:0] {
        ETM_MAP_TARGET,
        ETM_MAP_HOST,
        ETM_MAP_NONEXIST
    } etm_map_e;

    // One sampled machine state
    typedef struct packed {
        logic [3:0] status;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [1:0] serial;
        logic [EXT_W-1:0] ext;
    } etm_frame_s;

    // Three-valued matcher: care mask and value
    typedef struct packed {
        logic [CHAN_W-1:0] care;
        logic [CHAN_W-1:0] value;
    } etm_match_s;
endpackage : etm_pkg

// file: dv/etm_asserts.sv
// Purpose: Port assertions for the emulator trace and map core
// Assumes: One clock, async active-low reset
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module etm_asserts
    import etm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [REG_DATA_W-1:0] reg_rdata,
    input wire logic route_host,
    input wire logic access_error,
    input wire logic emulating,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic run_q;
    logic irq_q;
    // Remember last cycle's run and interrupt register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            run_q <= reg_write && reg_addr == OFF_CONTROL && reg_wdata[CTL_RUN_BIT];
            irq_q <= reg_write && (reg_addr == OFF_IRQ_STATUS || reg_addr == OFF_IRQ_MASK);
        end
    end
    sequence s_run_wr;
        reg_write && reg_addr == OFF_CONTROL && reg_wdata[CTL_RUN_BIT];
    endsequence
    sequence s_stop_wr;
        reg_write && reg_addr == OFF_CONTROL && !reg_wdata[CTL_RUN_BIT];
    endsequence
    property p_rdata_idle;
        !$past(reg_read) |-> reg_rdata == RESET_WORD;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
    property p_unmapped;
        reg_read && reg_addr > OFF_MAP_END |=> reg_rdata == RESET_WORD;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_run_start;
        s_run_wr |=> emulating;
    endproperty
    a_run_start: assert property (p_run_start) else $error("run write did not start emulation");
    property p_run_cause;
        $rose(emulating) |-> run_q;
    endproperty
    a_run_cause: assert property (p_run_cause) else $error("emulation started without run write");
    property p_run_stop;
        s_stop_wr |=> !emulating;
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("stop write ignored");
    property p_err_stop;
        access_error |-> ##[0:16] !emulating;
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("nonexistent access did not stop");
    property p_irq_fall;
        $fell(irq) |-> irq_q;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
    property p_quiet;
        !emulating [*3] |-> !route_host && !access_error;
    endproperty
    a_quiet: assert property (p_quiet) else $error("routing active while stopped");
    property p_excl;
        !(route_host && access_error);
    endproperty
    a_excl: assert property (p_excl) else $error("host and nonexistent together");
endmodule : etm_asserts
`default_nettype wire

// file: dv/etm_proto_model.sv
// Purpose: Prototype processor side driving the probe pins
// Assumes: Pins change just after clk edges
// Notes: Released lines show the inverse of the last state
`timescale 1ns/10ps
`default_nettype none
module etm_proto_model
    import etm_pkg::*;
(
    input wire logic clk,
    output logic emu_clk_pin,
    output logic state_strobe_pin,
    output logic fetch_pin,
    output etm_frame_s frame
);
    // Idle pins at time zero
    initial begin
        emu_clk_pin = 1'b0;
        state_strobe_pin = 1'b0;
        fetch_pin = 1'b0;
        frame = '0;
    end
    // One state: status, address, data, serial, 18 external lines, then strobe
    task automatic drive(input etm_frame_s f, input logic fe);
        @(posedge clk);
        frame <= f;
        fetch_pin <= fe;
        emu_clk_pin <= 1'b1;
        repeat (3) @(posedge clk);
        emu_clk_pin <= 1'b0;
        repeat (3) @(posedge clk);
        state_strobe_pin <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : drive
    // Drop strobe, then let the lines go
    task automatic release_bus();
        @(posedge clk);
        state_strobe_pin <= 1'b0;
        repeat (4) @(posedge clk);
        frame <= ~frame;
        fetch_pin <= ~fetch_pin;
    endtask : release_bus
endmodule : etm_proto_model
`default_nettype wire

// file: dv/etm_tb.sv
// Purpose: Self-checking bench for the emulator trace and map core
// Assumes: Register port with one-cycle read answer
// Notes: Reference model keeps trace, cycle count and last fetch
`timescale 1ns/10ps
`default_nettype none
module tb import etm_pkg::*; ;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [REG_ADDR_W-1:0] reg_addr = '0;
    logic [REG_DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [REG_DATA_W-1:0] reg_rdata;
    logic emu_clk_pin, state_strobe_pin, fetch_pin;
    logic route_host, access_error, emulating, irq;
    etm_frame_s pf;
    int err_count = 0;
    int tests_run = 0;
    int seed = 17712;
    int m[BLOCK_COUNT];
    etm_frame_s q[$];
    logic [31:0] cyc = '0;
    logic [15:0] last_pc = '0;
    logic run_x = 1'b0;
    always #5 clk = ~clk;
    etm_proto_model i_pm (.clk(clk), .emu_clk_pin(emu_clk_pin), .state_strobe_pin(state_strobe_pin),
        .fetch_pin(fetch_pin), .frame(pf));
    etm_core i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .emu_clk_pin(emu_clk_pin),
        .state_strobe_pin(state_strobe_pin), .fetch_pin(fetch_pin), .status_pin(pf.status),
        .addr_pin(pf.addr), .data_pin(pf.data), .serial_pin(pf.serial), .ext_pin(pf.ext),
        .route_host(route_host), .access_error(access_error), .emulating(emulating), .irq(irq));
    task automatic report_and_stop();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // Read strobe one cycle, data taken in the following cycle
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(n, reg_rdata, e);
    endtask : rc
    function automatic etm_frame_s mk(input logic [4:0] blk, input logic [3:0] st);
        etm_frame_s f;
        f = etm_frame_s'(48'({$random(seed), $random(seed)}));
        f.status = st;
        f.addr[15:11] = blk;
        return f;
    endfunction : mk
    function automatic logic [3:0] rst();
        return 4'($unsigned($random(seed)) % 15);
    endfunction : rst
    task automatic run_ctl(input logic go);
        wr(OFF_CONTROL, {31'h0, go});
        run_x = go;
        #1;
        check("emulating", {31'h0, emulating}, {31'h0, go});
    endtask : run_ctl
    // Send a state and advance the reference model
    task automatic sendst(input etm_frame_s f, input logic fe);
        i_pm.drive(f, fe);
        #1;
        cyc = cyc + 32'h1;
        if (fe) last_pc = f.addr;
        if (q.size() == TRACE_MAX_COUNT) void'(q.pop_front());
        q.push_back(f);
        if (m[f.addr[15:11]] == 2 || f.status == 4'hF) run_x = 1'b0;
        check("emulating", {31'h0, emulating}, {31'h0, run_x});
        check("route", {31'h0, route_host}, {31'h0, run_x && m[f.addr[15:11]] == 1});
        i_pm.release_bus();
    endtask : sendst
    task automatic verify();
        rc("cyc_lo", OFF_CYCLE_LOW, {16'h0, cyc[15:0]});
        rc("cyc_hi", OFF_CYCLE_HIGH, {16'h0, cyc[31:16]});
        rc("last_pc", OFF_LAST_INSTR, {16'h0, last_pc});
        rc("count", OFF_FRAME_COUNT, 32'(q.size()));
        for (int i = 0; i < q.size(); i++) begin
            logic [41:0] c;
            c = {2'b00, q[i].status, q[i].addr[15:8], q[i].data, q[i].serial, q[i].ext};
            wr(OFF_TRACE_INDEX, 32'(i));
            rc("tr_lo", OFF_TRACE_LOW, c[31:0]);
            rc("tr_hi", OFF_TRACE_HIGH, {22'h0, c[41:32]});
        end
    endtask : verify
    // Watchdog against a hang
    initial begin
        repeat (99000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rc("ctl", OFF_CONTROL, 32'h0);
        rc("map0", OFF_MAP_BASE, 32'h0);
        rc("gap", 8'h0B, 32'h0);
        rc("gap", 8'h40, 32'h0);
        for (int b = 0; b < BLOCK_COUNT; b++) begin
            m[b] = (b == 2) ? 1 : (b == 5) ? 2 : (b inside {0, 1, 26, 29, 30}) ? 0 : $unsigned($random(seed)) % 3;
            wr(OFF_MAP_BASE + 8'(b), 32'(m[b]));
        end
        for (int b = 0; b < BLOCK_COUNT; b++) rc("map", OFF_MAP_BASE + 8'(b), 32'(m[b]));
        for (int n = 0; n < 2; n++) begin
            wr(OFF_MATCH_BASE + 8'(4 * n + 1), 32'h000000F0);
            wr(OFF_MATCH_BASE + 8'(4 * n + 3), 32'h000000F0);
        end
        wr(OFF_IRQ_MASK, 32'h00000007);
        run_ctl(1'b1);
        for (int k = 0; k < 6; k++) sendst(mk((k == 3) ? 5'h02 : 5'h01, rst()), k[0]);
        run_ctl(1'b0);
        run_ctl(1'b1);
        sendst(mk(5'h05, rst()), 1'b0);
        rc("irq_st", OFF_IRQ_STATUS, 32'h1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STATUS, 32'h1);
        #1;
        check("irq", {31'h0, irq}, 32'h0);
        run_ctl(1'b1);
        sendst(mk(5'h01, 4'hF), 1'b0);
        rc("irq_st", OFF_IRQ_STATUS, 32'h2);
        wr(OFF_IRQ_STATUS, 32'h2);
        verify();
        wr(OFF_CONTROL, 32'h2);
        q.delete();
        cyc = '0;
        rc("count", OFF_FRAME_COUNT, 32'h0);
        run_ctl(1'b1);
        repeat (1030) sendst(mk(5'(1 + ($unsigned($random(seed)) % 2)), rst()), 1'($random(seed)));
        rc("irq_st", OFF_IRQ_STATUS, 32'h4);
        run_ctl(1'b0);
        verify();
        report_and_stop();
    end
endmodule : tb
bind etm_core etm_asserts i_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .route_host(route_host), .access_error(access_error), .emulating(emulating), .irq(irq));
`default_nettype wire

// file: logic/etm_core.sv
// Purpose: Memory map, cycle timer, last instruction address and trace capture
// Assumes: Probe inputs come from another clock domain and are synchronised here
// Notes: One machine state is presented per probe strobe edge
//
// Behaviour
// - Target memory split into 32 blocks of 2K bytes.
// - Each block holds its own independent map setting.
// - Host-mapped blocks steer accesses to host memory or I/O.
// - Any block may be marked nonexistent by its map setting.
// - Access to a nonexistent block raises a host-visible error.
// - Count emulation clock pulses; low 16 bits readable as low word.
// - High 16 bits of the same 32-bit counter readable separately.
// - Keep the address of the last emulated instruction after break.
// - Keep a count of valid trace frames, 0 to 1022.
// - Trace buffer 1023 entries deep, 42 channels wide.
// - Accept 18 external signals as extra trace channels.
// - Record status, upper address byte, data, serial, external per state; keep last 1022.
// - Two 42-channel three-valued breakpoints stop emulation on match.
// - Two three-valued qualifiers decide which states enter the trace.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module etm_core
    import etm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [REG_DATA_W-1:0] reg_rdata,
    // Prototype probe inputs
    input wire logic emu_clk_pin,
    input wire logic state_strobe_pin,
    input wire logic fetch_pin,
    input wire logic [3:0] status_pin,
    input wire logic [ADDR_W-1:0] addr_pin,
    input wire logic [7:0] data_pin,
    input wire logic [1:0] serial_pin,
    input wire logic [EXT_W-1:0] ext_pin,
    // Routing and control outputs
    output logic route_host,
    output logic access_error,
    output logic emulating,
    output logic irq
);

    // ******************************************************************
    // Input synchronisers
    // ******************************************************************
    localparam int SYNC_W = 1 + 1 + 1 + $bits(etm_frame_s);
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_out;

    // Two flops on every probe pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_meta <= '0;
            sync_out <= '0;
        end else begin
            sync_meta <= {emu_clk_pin, state_strobe_pin, fetch_pin, status_pin, addr_pin, data_pin,
                          serial_pin, ext_pin};
            sync_out <= sync_meta;
        end
    end

    logic emu_clk_s;
    logic strobe_s;
    logic fetch_s;
    etm_frame_s frame_s;
    assign {emu_clk_s, strobe_s, fetch_s, frame_s} = sync_out;

    // ******************************************************************
    // Edge detection on synchronised clock and strobe
    // ******************************************************************
    logic emu_clk_d;
    logic strobe_d;
    logic next_emu_clk_d;
    logic next_strobe_d;

    // Previous levels for edge detection
    always_comb begin
        next_emu_clk_d = emu_clk_s;
        next_strobe_d = strobe_s;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            emu_clk_d <= 1'b0;
            strobe_d <= 1'b0;
        end else begin
            emu_clk_d <= next_emu_clk_d;
            strobe_d <= next_strobe_d;
        end
    end

    logic emu_pulse;
    logic state_evt;
    assign emu_pulse = emu_clk_s & ~emu_clk_d;
    assign state_evt = strobe_s & ~strobe_d;

    // ******************************************************************
    // Memory map and matchers
    // ******************************************************************
    etm_map_e map_mem [BLOCK_COUNT];
    etm_match_s match_reg [4];        // 0,1 break; 2,3 qualify
    logic [BLOCK_IDX_W-1:0] blk_idx;
    etm_map_e blk_map;
    logic [3:0] match_hit;
    logic [CHAN_W-1:0] chan_vec;

    assign blk_idx = frame_s.addr[ADDR_W-1 -: BLOCK_IDX_W];
    assign blk_map = map_mem[blk_idx];
    // 42 channels: two spare zeros, status, upper address byte, data/AD byte, serial, external
    assign chan_vec = {2'b00, frame_s.status, frame_s.addr[ADDR_W-1:8], frame_s.data, frame_s.serial, frame_s.ext};

    // Three-valued compare per matcher
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_match
            assign match_hit[gi] = ((chan_vec ^ match_reg[gi].value) & match_reg[gi].care) == '0;
        end
    endgenerate

    logic nonexist_hit;
    logic break_hit;
    logic qualify_hit;
    assign nonexist_hit = emulating & state_evt & (blk_map == ETM_MAP_NONEXIST);
    assign break_hit = emulating & state_evt & (match_hit[0] | match_hit[1]);
    assign qualify_hit = match_hit[2] | match_hit[3];

    // ******************************************************************
    // Routing outputs
    // ******************************************************************
    logic next_route_host;
    logic next_access_error;

    // Route host-mapped accesses away from the target; flag nonexistent blocks
    always_comb begin
        next_route_host = emulating & (blk_map == ETM_MAP_HOST);
        next_access_error = emulating & (blk_map == ETM_MAP_NONEXIST);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            route_host <= 1'b0;
            access_error <= 1'b0;
        end else begin
            route_host <= next_route_host;
            access_error <= next_access_error;
        end
    end

    // ******************************************************************
    // Register decode strobes
    // ******************************************************************
    logic wr_ctl;
    logic wr_irq_st;
    logic wr_irq_mask;
    logic wr_tidx;
    logic wr_map;
    logic wr_match;
    assign wr_ctl = reg_write & (reg_addr == OFF_CONTROL);
    assign wr_irq_st = reg_write & (reg_addr == OFF_IRQ_STATUS);
    assign wr_irq_mask = reg_write & (reg_addr == OFF_IRQ_MASK);
    assign wr_tidx = reg_write & (reg_addr == OFF_TRACE_INDEX);
    assign wr_map = reg_write & (reg_addr >= OFF_MAP_BASE) & (reg_addr <= OFF_MAP_END);
    assign wr_match = reg_write & (reg_addr >= OFF_MATCH_BASE) & (reg_addr < OFF_MAP_BASE);

    // Map and matcher storage writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < BLOCK_COUNT; i++) begin
                map_mem[i] <= ETM_MAP_TARGET;
            end
            for (int i = 0; i < 4; i++) begin
                match_reg[i] <= '0;
            end
        end else begin
            if (wr_map) begin
                map_mem[reg_addr[BLOCK_IDX_W-1:0]] <= etm_map_e'(reg_wdata[1:0]);
            end
            if (wr_match) begin
                case (reg_addr[1:0])
                    2'h0: match_reg[reg_addr[3:2]].care[31:0] <= reg_wdata;
                    2'h1: match_reg[reg_addr[3:2]].care[CHAN_W-1:32] <= reg_wdata[CHAN_W-33:0];
                    2'h2: match_reg[reg_addr[3:2]].value[31:0] <= reg_wdata;
                    default: match_reg[reg_addr[3:2]].value[CHAN_W-1:32] <= reg_wdata[CHAN_W-33:0];
                endcase
            end
        end
    end

    // ******************************************************************
    // Emulation control, timer, last instruction, trace pointers
    // ******************************************************************
    logic [31:0] cycle_count;
    logic [ADDR_W-1:0] last_instruction_address;
    logic [TRACE_PTR_W-1:0] wr_ptr;
    logic [TRACE_PTR_W-1:0] valid_trace_frame_count;
    logic [TRACE_PTR_W-1:0] trace_index;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic next_emulating;
    logic [31:0] next_cycle_count;
    logic [ADDR_W-1:0] next_last_instruction_address;
    logic [TRACE_PTR_W-1:0] next_wr_ptr;
    logic [TRACE_PTR_W-1:0] next_valid_trace_frame_count;
    logic [TRACE_PTR_W-1:0] next_trace_index;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    logic trace_write;
    logic wrap_evt;
    logic stop_evt;

    assign stop_evt = break_hit | nonexist_hit;
    assign trace_write = emulating & state_evt & qualify_hit;
    assign wrap_evt = trace_write & (wr_ptr == TRACE_LAST_IDX);

    // Next state of control and counters
    always_comb begin
        next_emulating = emulating;
        next_cycle_count = cycle_count;
        next_last_instruction_address = last_instruction_address;
        next_wr_ptr = wr_ptr;
        next_valid_trace_frame_count = valid_trace_frame_count;
        next_trace_index = trace_index;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (wr_ctl) begin
            next_emulating = reg_wdata[CTL_RUN_BIT];
            if (reg_wdata[CTL_CLEAR_BIT]) begin
                next_cycle_count = '0;
                next_wr_ptr = '0;
                next_valid_trace_frame_count = '0;
            end
        end
        if (stop_evt) begin
            next_emulating = 1'b0;
        end
        if (emulating & emu_pulse) begin
            next_cycle_count = cycle_count + 32'h00000001;
        end
        if (emulating & state_evt & fetch_s) begin
            next_last_instruction_address = frame_s.addr;
        end
        if (trace_write) begin
            next_wr_ptr = wrap_evt ? '0 : wr_ptr + 10'h001;
            if (valid_trace_frame_count != TRACE_COUNT_MAX) begin
                next_valid_trace_frame_count = valid_trace_frame_count + 10'h001;
            end
        end
        if (wr_tidx) begin
            next_trace_index = reg_wdata[TRACE_PTR_W-1:0];
        end
        if (wr_irq_mask) begin
            next_irq_mask = reg_wdata[IRQ_W-1:0];
        end
        // Write one to clear; new events win over the clear
        if (wr_irq_st) begin
            next_irq_status = irq_status & ~reg_wdata[IRQ_W-1:0];
        end
        next_irq_status[IRQ_NONEXIST_BIT] = next_irq_status[IRQ_NONEXIST_BIT] | nonexist_hit;
        next_irq_status[IRQ_BREAK_BIT] = next_irq_status[IRQ_BREAK_BIT] | break_hit;
        next_irq_status[IRQ_WRAP_BIT] = next_irq_status[IRQ_WRAP_BIT] | wrap_evt;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            emulating <= 1'b0;
            cycle_count <= '0;
            last_instruction_address <= '0;
            wr_ptr <= '0;
            valid_trace_frame_count <= '0;
            trace_index <= '0;
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            emulating <= next_emulating;
            cycle_count <= next_cycle_count;
            last_instruction_address <= next_last_instruction_address;
            wr_ptr <= next_wr_ptr;
            valid_trace_frame_count <= next_valid_trace_frame_count;
            trace_index <= next_trace_index;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ******************************************************************
    // Trace buffer
    // ******************************************************************
    logic [CHAN_W-1:0] trace_mem [TRACE_DEPTH];
    logic [CHAN_W-1:0] trace_rd;
    logic [TRACE_PTR_W-1:0] rd_slot;
    logic [TRACE_PTR_W:0] rd_sum;

    // Software index 0 is the oldest valid frame
    assign rd_sum = {1'b0, wr_ptr} + {1'b0, trace_index} + 11'h3FF - {1'b0, valid_trace_frame_count};
    assign rd_slot = (rd_sum >= 11'h3FF) ? 10'(rd_sum - 11'h3FF) : rd_sum[TRACE_PTR_W-1:0];
    assign trace_rd = trace_mem[(rd_slot > TRACE_LAST_IDX) ? '0 : rd_slot];

    // Frame store, overwriting the oldest entry
    always_ff @(posedge clk) begin
        if (trace_write) begin
            trace_mem[wr_ptr] <= chan_vec;
        end
    end

    // ******************************************************************
    // Register read port
    // ******************************************************************
    logic [REG_DATA_W-1:0] next_rdata;

    // Read decode, one cycle latency, zero for unmapped offsets
    always_comb begin
        next_rdata = RESET_WORD;
        if (!reg_read) begin
            next_rdata = RESET_WORD;
        end else if (reg_addr == OFF_CONTROL) begin
            next_rdata = {31'h00000000, emulating};
        end else if (reg_addr == OFF_STATUS) begin
            next_rdata = {16'h0000, wr_ptr, 4'h0, access_error, route_host};
        end else if (reg_addr == OFF_IRQ_STATUS) begin
            next_rdata = {29'h00000000, irq_status};
        end else if (reg_addr == OFF_IRQ_MASK) begin
            next_rdata = {29'h00000000, irq_mask};
        end else if (reg_addr == OFF_CYCLE_LOW) begin
            next_rdata = {16'h0000, cycle_count[15:0]};
        end else if (reg_addr == OFF_CYCLE_HIGH) begin
            next_rdata = {16'h0000, cycle_count[31:16]};
        end else if (reg_addr == OFF_LAST_INSTR) begin
            next_rdata = {16'h0000, last_instruction_address};
        end else if (reg_addr == OFF_FRAME_COUNT) begin
            next_rdata = {22'h000000, valid_trace_frame_count};
        end else if (reg_addr == OFF_TRACE_INDEX) begin
            next_rdata = {22'h000000, trace_index};
        end else if (reg_addr == OFF_TRACE_LOW) begin
            next_rdata = trace_rd[31:0];
        end else if (reg_addr == OFF_TRACE_HIGH) begin
            next_rdata = {22'h000000, trace_rd[CHAN_W-1:32]};
        end else if (reg_addr >= OFF_MAP_BASE && reg_addr <= OFF_MAP_END) begin
            next_rdata = {30'h00000000, map_mem[reg_addr[BLOCK_IDX_W-1:0]]};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= RESET_WORD;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : etm_core
`default_nettype wire
